// ===== wdr_assertions.sv
`timescale 1ns/1ps
module wdr_chk (
  // clock and block reset
  input wire logic                        mclk,
  input wire logic                        arst_n,
  // reset sources
  input wire logic                        brownout_detect,
  input wire logic                        external_reset_pin_n,
  input wire logic                        sw_reset_req,
  input wire logic                        prot_fault,
  input wire logic                        prot_fault_reset_sel,
  input wire logic                        hib_wake_evt,
  input wire logic [1:0]                  pwr_mode,
  // results
  input wire logic                        dev_reset_n,
  input wire logic                        prot_fault_irq,
  input wire logic [wdr_pkg::CAUSE_W-1:0] reset_cause
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);

  // one firmware request followed by a quiet edge
  sequence s_sw_pulse;
    sw_reset_req ##1 !sw_reset_req;
  endsequence

  // a fault routed to reset, then the device held
  sequence s_fault_rst;
    prot_fault && prot_fault_reset_sel ##1 !dev_reset_n;
  endsequence

  a_brownout_forces: assert property (brownout_detect |-> !dev_reset_n)
    else $error("brownout left reset high");
  a_pin_forces: assert property (!external_reset_pin_n |-> !dev_reset_n)
    else $error("pin low left reset high");
  a_sw_stretch: assert property (s_sw_pulse |-> !dev_reset_n [*8])
    else $error("software reset too short");
  a_sw_cause: assert property (sw_reset_req |=> reset_cause[wdr_pkg::CAUSE_SOFTWARE])
    else $error("software cause not recorded");
  a_fault_irq: assert property (prot_fault && !prot_fault_reset_sel && dev_reset_n
    |=> prot_fault_irq && dev_reset_n)
    else $error("fault interrupt missing");
  a_fault_reset: assert property (s_fault_rst |-> reset_cause[wdr_pkg::CAUSE_FAULT])
    else $error("fault reset cause missing");
  a_fault_pull: assert property (prot_fault && prot_fault_reset_sel |=> !dev_reset_n)
    else $error("fault did not reset");
  a_hib_wake: assert property (hib_wake_evt && pwr_mode == wdr_pkg::PWR_HIBERNATE
    |=> !dev_reset_n && reset_cause[wdr_pkg::CAUSE_HIBERNATE])
    else $error("hibernate wake not a reset");
endmodule : wdr_chk

// ===== wdr_pkg.sv
// Function
// - one basic watchdog, 16-bit free-running counter
// - two multi-counter watchdogs, 16/16/32-bit counters
// - every 16-bit counter can reset the device
// - every 16-bit counter can interrupt on match, the 32-bit counter on a selected bit toggle
// - basic watchdog counts internal low-speed oscillator ticks
// - basic watchdog interrupts and wakes in all modes
// - multi-counter watchdogs count low-frequency clock ticks
// - multi-counter wakeups not available in hibernate
// - unserviced enabled watchdog resets device after timeout
// - power-on holds reset until supply adequate
// - brownout detect forces reset on low supply
// - external reset pin is active low
// - firmware request causes full device reset
// - protection fault gives interrupt or reset, configurable
// - hibernate wakeup leaves via device reset
// - power-on, supply, brownout and pin resets are asynchronous; all resets restore known state
// - retained register records the reset cause
package wdr_pkg;

  // multi-counter mode codes for each 16-bit counter
  localparam logic [1:0] MC_MODE_NONE     = 2'h0;
  localparam logic [1:0] MC_MODE_INT      = 2'h1;
  localparam logic [1:0] MC_MODE_RESET    = 2'h2;
  localparam logic [1:0] MC_MODE_INT_RST  = 2'h3;

  // system power mode codes
  localparam logic [1:0] PWR_LP           = 2'h0;
  localparam logic [1:0] PWR_ULP          = 2'h1;
  localparam logic [1:0] PWR_DEEP_SLEEP   = 2'h2;
  localparam logic [1:0] PWR_HIBERNATE    = 2'h3;

  // reset cause bit positions
  localparam int CAUSE_BASIC_WDT = 0;
  localparam int CAUSE_MC_WDT    = 1;
  localparam int CAUSE_SOFTWARE  = 2;
  localparam int CAUSE_FAULT     = 3;
  localparam int CAUSE_HIBERNATE = 4;
  localparam int CAUSE_BROWNOUT  = 5;
  localparam int CAUSE_EXT_PIN   = 6;
  localparam int CAUSE_W         = 7;
  localparam logic [CAUSE_W-1:0] CAUSE_RESET = 7'h00;

  // counter reset values
  localparam logic [15:0] CNT16_RESET = 16'h0000;
  localparam logic [31:0] CNT32_RESET = 32'h0000_0000;

  // internal reset stretch: least time, rounded up to cycles
  localparam int CLK_PERIOD_PS   = 10000;
  localparam int RST_HOLD_NS     = 100;
  localparam int RST_HOLD_CYC    = (RST_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int RST_HOLD_W      = 8;
  localparam logic [RST_HOLD_W-1:0] RST_HOLD_ZERO = 8'h00;

endpackage : wdr_pkg

// ===== wdr_top.sv
`timescale 1ns/1ps
module wdr_top #(
  parameter int NUM_MC = 2
) (
  // clock and block reset (power-on domain)
  input  wire logic                          mclk,
  input  wire logic                          arst_n,
  // timebase ticks, one-cycle pulses
  input  wire logic                          ilo_tick,
  input  wire logic                          wco_tick,
  input  wire logic                          lf_src_wco,
  // system power mode
  input  wire logic [1:0]                    pwr_mode,
  // analog and pin reset sources
  input  wire logic                          supply_ok,
  input  wire logic                          brownout_detect,
  input  wire logic                          external_reset_pin_n,
  // firmware requests and faults
  input  wire logic                          sw_reset_req,
  input  wire logic                          prot_fault,
  input  wire logic                          prot_fault_reset_sel,
  input  wire logic                          hib_wake_evt,
  // basic watchdog control
  input  wire logic                          bw_enable,
  input  wire logic                          bw_reset_enable,
  input  wire logic [15:0]                   bw_match,
  input  wire logic                          bw_service,
  // multi-counter watchdog control
  input  wire logic [NUM_MC-1:0][1:0]        mc_enable16,
  input  wire logic [NUM_MC-1:0]             mc_enable32,
  input  wire logic [NUM_MC-1:0][1:0][1:0]   mc_mode,
  input  wire logic [NUM_MC-1:0][1:0][15:0]  mc_match16,
  input  wire logic [NUM_MC-1:0][4:0]        mc_bit_sel32,
  input  wire logic [NUM_MC-1:0]             mc_service,
  // cause register clear, write-one-to-clear
  input  wire logic [wdr_pkg::CAUSE_W-1:0]   cause_clear,
  // outputs
  output logic                               dev_reset_n,
  output logic                               bw_irq,
  output logic [NUM_MC-1:0][2:0]             mc_irq,
  output logic                               prot_fault_irq,
  output logic                               wakeup,
  output logic [15:0]                        bw_count,
  output logic [wdr_pkg::CAUSE_W-1:0]        reset_cause
);

  typedef struct packed {
    logic [15:0]                         bw_cnt;
    logic                                bw_warn;
    logic                                bw_irq;
    logic                                pf_irq;
    logic                                wake;
    logic [wdr_pkg::RST_HOLD_W-1:0]      hold;
    logic [wdr_pkg::CAUSE_W-1:0]         cause;
  } wdr_state_t;

  localparam logic [wdr_pkg::RST_HOLD_W-1:0] HOLD_LOAD =
    wdr_pkg::RST_HOLD_W'(wdr_pkg::RST_HOLD_CYC);

  wdr_state_t                     st_ff;
  wdr_state_t                     nxt_st;
  logic                           lf_tick;
  logic                           hibernate;
  logic                           ext_reset;
  logic                           dev_in_reset;
  logic                           mc_step;
  logic [NUM_MC-1:0]              mc_irq_evt;
  logic [NUM_MC-1:0]              mc_rst_hit;

  // low-frequency clock source select
  assign lf_tick   = lf_src_wco ? wco_tick : ilo_tick;
  assign hibernate = (pwr_mode == wdr_pkg::PWR_HIBERNATE);
  assign ext_reset = ~external_reset_pin_n;

  // device reset asserts without the clock from power-on, supply, brownout and pin; other sources through the stretch counter
  assign dev_in_reset = ~arst_n | ~supply_ok | brownout_detect | ext_reset |
                        (st_ff.hold != wdr_pkg::RST_HOLD_ZERO);
  assign dev_reset_n  = ~dev_in_reset;

  // multi-counter units step on low-frequency ticks, frozen in hibernate
  assign mc_step = lf_tick & ~hibernate;

  // one unit per multi-counter watchdog
  for (genvar m = 0; m < NUM_MC; m++) begin : g_mcw
    wdr_mcw i_mcw (
      .mclk      (mclk),
      .arst_n    (arst_n),
      .step      (mc_step),
      .dev_clear (dev_in_reset),
      .enable16  (mc_enable16[m]),
      .enable32  (mc_enable32[m]),
      .mode      (mc_mode[m]),
      .match16   (mc_match16[m]),
      .bit_sel32 (mc_bit_sel32[m]),
      .service   (mc_service[m]),
      .irq       (mc_irq[m]),
      .irq_evt   (mc_irq_evt[m]),
      .rst_hit   (mc_rst_hit[m])
    );
  end

  // next-state logic
  always_comb begin
    logic [wdr_pkg::CAUSE_W-1:0] set_cause;
    logic                        bw_hit;
    logic                        mc_hit;
    logic                        rst_req;
    logic                        wake_evt;
    nxt_st    = st_ff;
    set_cause = wdr_pkg::CAUSE_RESET;
    bw_hit    = 1'b0;
    mc_hit    = 1'b0;
    rst_req   = 1'b0;
    wake_evt  = 1'b0;
    nxt_st.bw_irq = 1'b0;
    nxt_st.pf_irq = 1'b0;
    nxt_st.wake   = 1'b0;

    // basic watchdog: free-running counter on oscillator ticks
    if (bw_service) begin
      nxt_st.bw_cnt  = wdr_pkg::CNT16_RESET;
      nxt_st.bw_warn = 1'b0;
    end else if (bw_enable && ilo_tick) begin
      nxt_st.bw_cnt = st_ff.bw_cnt + 16'h0001;
      if (st_ff.bw_cnt == bw_match) begin
        nxt_st.bw_irq = 1'b1;
        wake_evt      = 1'b1;
        if (st_ff.bw_warn && bw_reset_enable) begin
          bw_hit = 1'b1;
        end
        nxt_st.bw_warn = 1'b1;
      end
    end

    // multi-counter events from the unit instances
    mc_hit = |mc_rst_hit;
    if (|mc_irq_evt) begin
      wake_evt = 1'b1;
    end

    // protection fault routed to interrupt or reset
    if (prot_fault) begin
      if (prot_fault_reset_sel) begin
        rst_req = 1'b1;
        set_cause[wdr_pkg::CAUSE_FAULT] = 1'b1;
      end else begin
        nxt_st.pf_irq = 1'b1;
      end
    end

    // software reset request
    if (sw_reset_req) begin
      rst_req = 1'b1;
      set_cause[wdr_pkg::CAUSE_SOFTWARE] = 1'b1;
    end

    // hibernate is left only through a device reset
    if (hibernate && (wake_evt || hib_wake_evt)) begin
      rst_req = 1'b1;
      set_cause[wdr_pkg::CAUSE_HIBERNATE] = 1'b1;
    end else begin
      nxt_st.wake = wake_evt;
    end

    if (bw_hit) begin
      rst_req = 1'b1;
      set_cause[wdr_pkg::CAUSE_BASIC_WDT] = 1'b1;
    end
    if (mc_hit) begin
      rst_req = 1'b1;
      set_cause[wdr_pkg::CAUSE_MC_WDT] = 1'b1;
    end
    if (brownout_detect) begin
      set_cause[wdr_pkg::CAUSE_BROWNOUT] = 1'b1;
    end
    if (ext_reset) begin
      set_cause[wdr_pkg::CAUSE_EXT_PIN] = 1'b1;
    end

    // reset stretch counter
    if (rst_req) begin
      nxt_st.hold = HOLD_LOAD;
    end else if (st_ff.hold != wdr_pkg::RST_HOLD_ZERO) begin
      nxt_st.hold = st_ff.hold - 8'h01;
    end

    // watchdogs return to a known state during any device reset
    if (dev_in_reset) begin
      nxt_st.bw_cnt   = wdr_pkg::CNT16_RESET;
      nxt_st.bw_warn  = 1'b0;
      nxt_st.bw_irq   = 1'b0;
      nxt_st.pf_irq   = 1'b0;
      nxt_st.wake     = 1'b0;
    end

    // retained cause: survives device reset, set wins over clear
    nxt_st.cause = (st_ff.cause & ~cause_clear) | set_cause;
  end

  // state register, cleared only by power-on
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // outputs from flip-flops
  assign bw_irq         = st_ff.bw_irq;
  assign prot_fault_irq = st_ff.pf_irq;
  assign wakeup         = st_ff.wake;
  assign bw_count       = st_ff.bw_cnt;
  assign reset_cause    = st_ff.cause;

endmodule : wdr_top

// one multi-counter watchdog: two 16-bit match counters and a 32-bit toggle counter
module wdr_mcw (
  // clock and block reset
  input  wire logic             mclk,
  input  wire logic             arst_n,
  // count qualifiers
  input  wire logic             step,
  input  wire logic             dev_clear,
  // configuration
  input  wire logic [1:0]       enable16,
  input  wire logic             enable32,
  input  wire logic [1:0][1:0]  mode,
  input  wire logic [1:0][15:0] match16,
  input  wire logic [4:0]       bit_sel32,
  input  wire logic             service,
  // results
  output logic [2:0]            irq,
  output logic                  irq_evt,
  output logic                  rst_hit
);

  typedef struct packed {
    logic [31:0] cnt32;
    logic [2:0]  irq;
  } wdr_mcw_state_t;

  wdr_mcw_state_t st_ff;
  wdr_mcw_state_t nxt_st;
  logic [1:0]     c16_irq;
  logic [1:0]     c16_hit;

  // the two 16-bit counters; service does not touch the 32-bit one
  for (genvar c = 0; c < 2; c++) begin : g_c16
    wdr_mc_cnt16 i_c16 (
      .mclk    (mclk),
      .arst_n  (arst_n),
      .step    (step),
      .clear   (service | dev_clear),
      .enable  (enable16[c]),
      .mode    (mode[c]),
      .match   (match16[c]),
      .irq_set (c16_irq[c]),
      .rst_hit (c16_hit[c])
    );
  end

  // 32-bit counter interrupts when its selected bit changes
  always_comb begin
    logic [31:0] cnt_inc;
    cnt_inc    = st_ff.cnt32 + 32'h0000_0001;
    nxt_st     = st_ff;
    nxt_st.irq = {1'b0, c16_irq};
    if (dev_clear) begin
      nxt_st.cnt32 = wdr_pkg::CNT32_RESET;
      nxt_st.irq   = 3'h0;
    end else if (step && enable32) begin
      nxt_st.cnt32  = cnt_inc;
      nxt_st.irq[2] = (st_ff.cnt32[bit_sel32] != cnt_inc[bit_sel32]);
    end
  end

  // unit state, cleared only by power-on
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // interrupt pulses registered, events for wakeup and reset combinational
  assign irq     = st_ff.irq;
  assign irq_evt = |nxt_st.irq;
  assign rst_hit = |c16_hit;

endmodule : wdr_mcw

// one 16-bit match counter of a multi-counter unit
module wdr_mc_cnt16 (
  // clock and block reset
  input  wire logic        mclk,
  input  wire logic        arst_n,
  // count qualifiers
  input  wire logic        step,
  input  wire logic        clear,
  // configuration
  input  wire logic        enable,
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] match,
  // match results, valid in the cycle of the counting edge
  output logic             irq_set,
  output logic             rst_hit
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        warn;
  } wdr_c16_state_t;

  wdr_c16_state_t st_ff;
  wdr_c16_state_t nxt_st;

  // count to the match value, reload, then act on the mode
  always_comb begin
    nxt_st  = st_ff;
    irq_set = 1'b0;
    rst_hit = 1'b0;
    if (clear) begin
      nxt_st.cnt  = wdr_pkg::CNT16_RESET;
      nxt_st.warn = 1'b0;
    end else if (step && enable) begin
      if (st_ff.cnt == match) begin
        nxt_st.cnt = wdr_pkg::CNT16_RESET;
        unique case (mode)
          wdr_pkg::MC_MODE_NONE: begin
          end
          wdr_pkg::MC_MODE_INT: begin
            irq_set = 1'b1;
          end
          wdr_pkg::MC_MODE_RESET: begin
            rst_hit = 1'b1;
          end
          wdr_pkg::MC_MODE_INT_RST: begin
            irq_set     = 1'b1;
            rst_hit     = st_ff.warn;
            nxt_st.warn = 1'b1; // first match only warns
          end
        endcase
      end else begin
        nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
    end
  end

  // counter state, cleared only by power-on
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : wdr_mc_cnt16

// ===== wdr_top_tb_top.sv
`timescale 1ns/1ps
module wdr_top_tb_top;
  logic                  mclk = 1'b0;
  logic                  arst_n, ilo_tick, wco_tick, lf_src_wco, supply_ok, brownout_detect;
  logic                  external_reset_pin_n, sw_reset_req, prot_fault, prot_fault_reset_sel;
  logic                  hib_wake_evt, bw_enable, bw_reset_enable, bw_service;
  logic                  dev_reset_n, bw_irq, prot_fault_irq, wakeup;
  logic [1:0]            pwr_mode, mc_enable32, mc_service;
  logic [15:0]           bw_match, bw_count;
  logic [1:0][1:0]       mc_enable16;
  logic [1:0][1:0][1:0]  mc_mode;
  logic [1:0][1:0][15:0] mc_match16;
  logic [1:0][4:0]       mc_bit_sel32;
  logic [1:0][2:0]       mc_irq;
  logic [6:0]            cause_clear, reset_cause;
  int                    bad_count = 0;
  int                    n_tests = 0;
  int                    cyc = 0;

  wdr_top #(.NUM_MC(2)) i_dut (.mclk, .arst_n, .ilo_tick, .wco_tick, .lf_src_wco, .pwr_mode,
    .supply_ok, .brownout_detect, .external_reset_pin_n, .sw_reset_req, .prot_fault,
    .prot_fault_reset_sel, .hib_wake_evt, .bw_enable, .bw_reset_enable, .bw_match, .bw_service,
    .mc_enable16, .mc_enable32, .mc_mode, .mc_match16, .mc_bit_sel32, .mc_service, .cause_clear,
    .dev_reset_n, .bw_irq, .mc_irq, .prot_fault_irq, .wakeup, .bw_count, .reset_cause);

  // clock and hang guard
  always #5 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 90000) begin
      bad_count++;
      final_report();
    end
  end

  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s exp %h got %h", what, exp, got);
    end
  endtask : chk

  // wait out a device reset, then clear the retained causes
  task automatic recover(logic [6:0] exp);
    for (int i = 0; i < 30 && dev_reset_n !== 1'b1; i++) @(posedge mclk);
    #1 chk("released", 1, dev_reset_n);
    chk("cause kept", {25'h0, exp}, {25'h0, reset_cause});
    @(posedge mclk) cause_clear <= 7'h7f;
    @(posedge mclk) cause_clear <= 7'h00;
    #1 chk("cause clear", 0, {25'h0, reset_cause});
  endtask : recover

  task automatic t_sw;
    @(posedge mclk) sw_reset_req <= 1'b1;
    @(posedge mclk) sw_reset_req <= 1'b0;
    repeat (8) @(posedge mclk);
    #1 chk("sw held", 0, dev_reset_n);
    recover(7'h04);
    $display("done sw reset");
  endtask : t_sw

  task automatic t_fault(logic sel);
    @(posedge mclk) prot_fault_reset_sel <= sel;
    prot_fault <= 1'b1;
    @(posedge mclk) prot_fault <= 1'b0;
    #1 chk("fault route", {sel, ~sel}, {dev_reset_n ^ 1'b1, prot_fault_irq});
    if (sel) recover(7'h08);
    $display("done fault %0d", sel);
  endtask : t_fault

  task automatic t_pins;
    @(posedge mclk) brownout_detect <= 1'b1;
    #1 chk("brownout", 0, dev_reset_n);
    @(posedge mclk) brownout_detect <= 1'b0;
    recover(7'h20);
    @(posedge mclk) external_reset_pin_n <= 1'b0;
    #1 chk("pin", 0, dev_reset_n);
    @(posedge mclk) external_reset_pin_n <= 1'b1;
    recover(7'h40);
    @(posedge mclk) supply_ok <= 1'b0;
    #1 chk("supply", 0, dev_reset_n);
    @(posedge mclk) supply_ok <= 1'b1;
    recover(7'h00);
    $display("done pins");
  endtask : t_pins

  task automatic t_basic;
    @(posedge mclk) {bw_enable, bw_reset_enable, ilo_tick} <= 3'b111;
    bw_match <= 16'h0002;
    for (int i = 0; i < 20 && bw_irq !== 1'b1; i++) @(posedge mclk);
    chk("bw irq count", 3, bw_count);
    chk("bw wakeup", 1, wakeup);
    for (int i = 0; i < 70000 && dev_reset_n !== 1'b0; i++) @(posedge mclk);
    ilo_tick <= 1'b0;
    #1 chk("bw reset", 0, dev_reset_n);
    recover(7'h01);
    @(posedge mclk) ilo_tick <= 1'b1;
    repeat (3) @(posedge mclk);
    bw_service <= 1'b1;
    @(posedge mclk) bw_service <= 1'b0;
    ilo_tick <= 1'b0;
    #1 chk("serviced", 0, bw_count);
    $display("done basic");
  endtask : t_basic

  task automatic t_mc;
    int i;
    @(posedge mclk) {lf_src_wco, wco_tick, bw_enable} <= 3'b110;
    {mc_enable16[0][0], mc_enable32[0]} <= 2'b11;
    mc_mode[0][0] <= wdr_pkg::MC_MODE_INT;
    mc_match16[0][0] <= 16'h0003;
    for (i = 0; i < 20 && mc_irq[0][0] !== 1'b1; i++) @(posedge mclk);
    @(posedge mclk);
    for (i = 1; i < 20 && mc_irq[0][0] !== 1'b1; i++) @(posedge mclk);
    chk("mc period", 4, i);
    chk("mc 32 irq", 1, mc_irq[0][2]);
    chk("bw idle", 0, bw_count);
    @(posedge mclk) pwr_mode <= wdr_pkg::PWR_HIBERNATE;
    repeat (2) @(posedge mclk);
    for (i = 0; i < 12 && mc_irq === 6'h00; i++) @(posedge mclk);
    chk("mc frozen", 12, i);
    hib_wake_evt <= 1'b1;
    @(posedge mclk) hib_wake_evt <= 1'b0;
    {wco_tick, pwr_mode} <= 3'b000;
    #1 chk("hib wake", 0, dev_reset_n);
    recover(7'h10);
    $display("done multi");
  endtask : t_mc

  // second unit on oscillator ticks: serviced warn, unserviced reset, plain reset mode
  task automatic t_mc_rst;
    int i;
    @(posedge mclk) {lf_src_wco, ilo_tick, mc_enable32[0]} <= 3'b010;
    {mc_enable16[1][1], mc_enable16[0][0]} <= 2'b10;
    mc_mode[1][1] <= wdr_pkg::MC_MODE_INT_RST;
    mc_match16[1][1] <= 16'h0002;
    for (i = 0; i < 20 && mc_irq[1][1] !== 1'b1; i++) @(posedge mclk);
    mc_service[1] <= 1'b1;
    @(posedge mclk) mc_service[1] <= 1'b0;
    for (i = 0; i < 20 && mc_irq[1][1] !== 1'b1; i++) @(posedge mclk);
    #1 chk("mc serviced", 1, dev_reset_n);
    chk("mc no cause", 0, {25'h0, reset_cause});
    for (i = 0; i < 20 && dev_reset_n !== 1'b0; i++) @(posedge mclk);
    {ilo_tick, mc_enable16[1][1]} <= 2'b00;
    #1 chk("mc reset", 0, dev_reset_n);
    recover(7'h02);
    @(posedge mclk) {ilo_tick, mc_enable16[1][0]} <= 2'b11;
    mc_mode[1][0] <= wdr_pkg::MC_MODE_RESET;
    mc_match16[1][0] <= 16'h0001;
    repeat (3) @(posedge mclk);
    {ilo_tick, mc_enable16[1][0]} <= 2'b00;
    #1 chk("mc plain rst", 0, {dev_reset_n, mc_irq[1]});
    recover(7'h02);
    $display("done multi reset");
  endtask : t_mc_rst

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  // inputs settled at time zero, block reset for five cycles
  initial begin
    {arst_n, ilo_tick, wco_tick, lf_src_wco, brownout_detect, sw_reset_req, prot_fault} = '0;
    {prot_fault_reset_sel, hib_wake_evt, bw_enable, bw_reset_enable, bw_service} = '0;
    {pwr_mode, mc_enable32, mc_service, bw_match, mc_enable16, mc_mode, mc_match16} = '0;
    {mc_bit_sel32, cause_clear} = '0;
    {supply_ok, external_reset_pin_n} = 2'b11;
    repeat (5) @(posedge mclk);
    arst_n <= 1'b1;
    @(posedge mclk);
    t_sw();
    t_fault(1'b0);
    t_fault(1'b1);
    t_pins();
    t_mc();
    t_mc_rst();
    t_basic();
    final_report();
  end
endmodule : wdr_top_tb_top

bind wdr_top wdr_chk i_chk (.mclk, .arst_n, .brownout_detect, .external_reset_pin_n,
  .sw_reset_req, .prot_fault, .prot_fault_reset_sel, .hib_wake_evt, .pwr_mode, .dev_reset_n,
  .prot_fault_irq, .reset_cause);
